// file: pbn_pkg.sv
// Purpose: Shared constants for the pixel binning datapath.
// Assumes: 12-bit pixels from the sensor readout, one pixel clock.
// Notes: Factor codes are log2 of the binning factor (0 = no binning).
package pbn_pkg;
    localparam int PIX_W = 12;
    localparam int SUM_W = 16;
    localparam int COL_W = 8;
    localparam int LINE_MAX = 256;
    localparam int FIFO_W = 13;
    localparam int FIFO_DEPTH = 4;
    localparam logic [PIX_W-1:0] PIX_MAX = 12'hFFF;
    localparam logic [SUM_W-1:0] SUM_MAX = 16'h0FFF;
    localparam logic [2:0] MODE_FULL_RES = 3'h0;
    localparam logic [2:0] MODE_H_BIN2 = 3'h1;
    localparam logic [2:0] MODE_V_BIN2 = 3'h2;
    localparam logic [2:0] MODE_F_BIN2 = 3'h3;
    localparam logic [2:0] MODE_H_SUB = 3'h4;
    localparam logic [2:0] MODE_V_SUB = 3'h5;
    localparam logic [2:0] MODE_F_SUB = 3'h6;
    localparam logic [1:0] FAC_1 = 2'h0;
    localparam logic [1:0] FAC_2 = 2'h1;
    localparam logic [1:0] SUB_PERIOD_LAST = 2'h3;
    typedef logic [1:0] pbn_fac_t;
endpackage

// file: pbn_binning.sv
// Purpose: Binning and sub-sampling of the sensor pixel stream.
// Assumes: Sensor stream is asynchronous to clk_sys_i and cannot stall.
// Notes: Format, mode and remap configuration is sampled on the first pixel of each frame; black level is used live.
// Contract
// R1 - Binning only in scalable format; mode selects type
// R2 - Offset, brightness, black level settings untouched
// R3 - Vertical binning sums 2, 4, 8 line pixels
// R4 - Horizontal binning combines without summing black level
// R5 - Full binning: vertical first, then horizontal
// R6 - Mode one defaults to 2x horizontal binning
// R7 - Mode two defaults to 2x vertical binning
// R8 - Mode three defaults to 2x full binning
// R9 - Sub-sampling skips same-colour neighbours, no combining
// R10 - Never binning and sub-sampling together
// R11 - Mode four defaults to 2-of-4 horizontal sub-sampling
// R12 - Horizontal sum saturates at maximum code
`timescale 1ns/1ps
`default_nettype none

module pbn_fifo #(
    parameter int W = 13,
    parameter int DEPTH = 4
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready_o = (count != (AW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o = mem[rptr];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            mem[wptr] <= in_data_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wptr <= '0;
            rptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wptr <= (wptr == LAST) ? '0 : wptr + 1'b1;
            end
            if (pop) begin
                rptr <= (rptr == LAST) ? '0 : rptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

module pbn_binning (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic pix_valid_i,
    input wire logic [pbn_pkg::PIX_W-1:0] pix_data_i,
    input wire logic pix_sof_i,
    input wire logic pix_eol_i,
    input wire logic fmt_scalable_i,
    input wire logic [2:0] mode_i,
    input wire logic map_en_i,
    input wire logic [1:0] map_hfac_i,
    input wire logic [1:0] map_vfac_i,
    input wire logic map_hsub_i,
    input wire logic map_vsub_i,
    input wire logic [pbn_pkg::PIX_W-1:0] black_level_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [pbn_pkg::PIX_W-1:0] out_data_o,
    output logic out_last_o,
    output logic src_ready_o,
    output logic overflow_o
);
    // Two-flop synchronisers for the sensor pins
    logic [pbn_pkg::PIX_W+2:0] sync1;
    logic [pbn_pkg::PIX_W+2:0] sync2;
    logic s_valid;
    logic s_sof;
    logic s_eol;
    logic [pbn_pkg::PIX_W-1:0] s_pix;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= {pix_valid_i, pix_sof_i, pix_eol_i, pix_data_i};
            sync2 <= sync1;
        end
    end

    assign s_valid = sync2[pbn_pkg::PIX_W+2];
    assign s_sof = sync2[pbn_pkg::PIX_W+1];
    assign s_eol = sync2[pbn_pkg::PIX_W];
    assign s_pix = sync2[pbn_pkg::PIX_W-1:0];

    // Mode decode
    pbn_pkg::pbn_fac_t dec_h;
    pbn_pkg::pbn_fac_t dec_v;
    logic dec_hsub;
    logic dec_vsub;

    always_comb begin
        dec_h = pbn_pkg::FAC_1;
        dec_v = pbn_pkg::FAC_1;
        dec_hsub = 1'b0;
        dec_vsub = 1'b0;
        if (fmt_scalable_i && mode_i != pbn_pkg::MODE_FULL_RES) begin // R1
            if (map_en_i) begin
                dec_hsub = map_hsub_i;
                dec_vsub = map_vsub_i;
                if (!(map_hsub_i || map_vsub_i)) begin // R10
                    dec_h = map_hfac_i;
                    dec_v = map_vfac_i;
                end
            end else begin
                case (mode_i)
                    pbn_pkg::MODE_H_BIN2: dec_h = pbn_pkg::FAC_2; // R6
                    pbn_pkg::MODE_V_BIN2: dec_v = pbn_pkg::FAC_2; // R7
                    pbn_pkg::MODE_F_BIN2: begin
                        dec_h = pbn_pkg::FAC_2; // R8
                        dec_v = pbn_pkg::FAC_2; // R8
                    end
                    pbn_pkg::MODE_H_SUB: dec_hsub = 1'b1; // R11
                    pbn_pkg::MODE_V_SUB: dec_vsub = 1'b1;
                    pbn_pkg::MODE_F_SUB: begin
                        dec_hsub = 1'b1;
                        dec_vsub = 1'b1;
                    end
                    default: dec_h = pbn_pkg::FAC_1;
                endcase
            end
        end
    end

    // Configuration held for the whole frame so a change cannot tear an image
    pbn_pkg::pbn_fac_t cfg_h;
    pbn_pkg::pbn_fac_t cfg_v;
    logic cfg_hsub;
    logic cfg_vsub;
    pbn_pkg::pbn_fac_t eff_h;
    pbn_pkg::pbn_fac_t eff_v;
    logic eff_hsub;
    logic eff_vsub;

    assign eff_h = s_sof ? dec_h : cfg_h;
    assign eff_v = s_sof ? dec_v : cfg_v;
    assign eff_hsub = s_sof ? dec_hsub : cfg_hsub;
    assign eff_vsub = s_sof ? dec_vsub : cfg_vsub;

    // Pipeline control
    logic c_valid;
    logic [pbn_pkg::PIX_W-1:0] c_data;
    logic c_last;
    logic f_in_ready;
    logic stall;
    logic accept;

    assign stall = c_valid && !f_in_ready;
    assign accept = s_valid && !stall;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_h <= pbn_pkg::FAC_1;
            cfg_v <= pbn_pkg::FAC_1;
            cfg_hsub <= 1'b0;
            cfg_vsub <= 1'b0;
        end else if (accept && s_sof) begin
            cfg_h <= dec_h;
            cfg_v <= dec_v;
            cfg_hsub <= dec_hsub;
            cfg_vsub <= dec_vsub;
        end
    end

    // Position counters
    logic [pbn_pkg::COL_W-1:0] col;
    logic [pbn_pkg::COL_W-1:0] cur_col;
    logic [2:0] vline;
    logic [2:0] cur_vline;
    logic [2:0] vlim;
    logic [2:0] hcnt;
    logic [2:0] cur_hcnt;
    logic [2:0] hlim;

    assign cur_col = s_sof ? '0 : col;
    assign cur_vline = s_sof ? '0 : vline;
    assign cur_hcnt = s_sof ? '0 : hcnt;
    assign vlim = eff_vsub ? 3'(pbn_pkg::SUB_PERIOD_LAST) : 3'((4'h1 << eff_v) - 4'h1);
    assign hlim = 3'((4'h1 << eff_h) - 4'h1);

    // Vertical accumulation over a line buffer, then horizontal combining
    logic [pbn_pkg::SUM_W-1:0] line_buf [pbn_pkg::LINE_MAX];
    logic [pbn_pkg::SUM_W-1:0] vsum;
    logic [pbn_pkg::PIX_W-1:0] vsat;
    logic [pbn_pkg::PIX_W-1:0] hval;
    logic [pbn_pkg::SUM_W-1:0] hacc;
    logic [pbn_pkg::SUM_W-1:0] hsum;
    logic [pbn_pkg::SUM_W-1:0] hout;
    logic line_keep;
    logic h_emit;
    logic emit;
    logic [pbn_pkg::PIX_W-1:0] emit_data;

    always_comb begin
        vsum = {{(pbn_pkg::SUM_W-pbn_pkg::PIX_W){1'b0}}, s_pix};
        if (!eff_vsub && cur_vline != 3'h0) begin
            vsum = line_buf[cur_col] + vsum; // R3
        end
        vsat = (vsum > pbn_pkg::SUM_MAX) ? pbn_pkg::PIX_MAX : vsum[pbn_pkg::PIX_W-1:0];
        // Black level removed per contributor and added back once
        hval = (vsat > black_level_i) ? vsat - black_level_i : '0; // R4
        hsum = ((cur_hcnt == 3'h0) ? '0 : hacc) + {4'h0, hval}; // R5
        hout = hsum + {4'h0, black_level_i}; // R2
        if (eff_vsub) begin
            line_keep = !cur_vline[1]; // R9
        end else begin
            line_keep = (cur_vline == vlim); // R3
        end
        h_emit = (cur_hcnt == hlim) || s_eol;
        if (eff_hsub) begin
            emit = line_keep && !cur_col[1]; // R9
            emit_data = vsat;
        end else if (eff_h == pbn_pkg::FAC_1) begin
            emit = line_keep;
            emit_data = vsat;
        end else begin
            emit = line_keep && h_emit;
            emit_data = (hout > pbn_pkg::SUM_MAX) ? pbn_pkg::PIX_MAX
                        : hout[pbn_pkg::PIX_W-1:0]; // R12
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (accept) begin
            line_buf[cur_col] <= vsum; // R3
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            col <= '0;
            vline <= '0;
            hcnt <= '0;
            hacc <= '0;
        end else if (accept) begin
            col <= s_eol ? '0 : cur_col + 1'b1;
            if (s_eol) begin
                vline <= (cur_vline == vlim) ? '0 : cur_vline + 1'b1;
            end else begin
                vline <= cur_vline;
            end
            hcnt <= (h_emit || eff_hsub) ? '0 : cur_hcnt + 1'b1;
            hacc <= hsum;
        end
    end

    // Output of the compute stage; pixels arriving while it stalls are lost
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            c_valid <= 1'b0;
            c_data <= '0;
            c_last <= 1'b0;
            overflow_o <= 1'b0;
        end else begin
            if (accept) begin
                c_valid <= emit;
                c_data <= emit_data;
                c_last <= s_eol;
            end else if (f_in_ready) begin
                c_valid <= 1'b0;
            end
            if (s_valid && stall) begin
                overflow_o <= 1'b1;
            end
        end
    end

    logic f_out_valid;
    logic f_out_ready;
    logic [pbn_pkg::FIFO_W-1:0] f_out_data;

    pbn_fifo #(
        .W(pbn_pkg::FIFO_W),
        .DEPTH(pbn_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(c_valid),
        .in_ready_o(f_in_ready),
        .in_data_i({c_last, c_data}),
        .out_valid_o(f_out_valid),
        .out_ready_i(f_out_ready),
        .out_data_o(f_out_data)
    );

    assign f_out_ready = !out_valid_o || out_ready_i;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            out_valid_o <= 1'b0;
            out_data_o <= '0;
            out_last_o <= 1'b0;
            src_ready_o <= 1'b0;
        end else begin
            src_ready_o <= f_in_ready;
            if (f_out_valid && f_out_ready) begin
                out_valid_o <= 1'b1;
                out_data_o <= f_out_data[pbn_pkg::PIX_W-1:0];
                out_last_o <= f_out_data[pbn_pkg::PIX_W];
            end else if (out_ready_i) begin
                out_valid_o <= 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

// file: pbn_binning_checker.sv
// Purpose: Port-level assertions for the pixel binning datapath.
// Assumes: One clock, asynchronous active-low reset.
// Notes: The lag counter saturates, so it bounds only the first output.
`timescale 1ns/1ps
`default_nettype none
module pbn_binning_checker (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic pix_valid_i,
    input wire logic pix_sof_i,
    input wire logic out_valid_o,
    input wire logic out_ready_i,
    input wire logic [pbn_pkg::PIX_W-1:0] out_data_o,
    input wire logic out_last_o,
    input wire logic src_ready_o,
    input wire logic overflow_o
);
    logic [3:0] since_pix;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) since_pix <= 4'h0;
        else if (since_pix != 4'h0 && since_pix != 4'hF) since_pix <= since_pix + 4'h1;
        else if (since_pix == 4'h0 && pix_valid_i) since_pix <= 4'h1;
    end
    a_valid_hold: assert property (out_valid_o && !out_ready_i |=> out_valid_o)
        else $error("output valid dropped while stalled");
    a_data_hold: assert property (out_valid_o && !out_ready_i |=> $stable(out_data_o))
        else $error("output data changed while stalled");
    a_last_hold: assert property (out_valid_o && !out_ready_i |=> $stable(out_last_o))
        else $error("line end flag changed while stalled");
    a_reset_idle: assert property (@(posedge clk_sys_i) disable iff (1'b0)
        !rst_n_i |-> !out_valid_o && !src_ready_o && !overflow_o)
        else $error("outputs active during reset");
    a_ready_release: assert property ($rose(rst_n_i) |=> src_ready_o)
        else $error("buffer not ready after reset");
    a_ovf_sticky: assert property (overflow_o |=> overflow_o)
        else $error("overflow flag cleared without reset");
    a_out_lag: assert property (out_valid_o |-> since_pix >= 4'h5)
        else $error("output earlier than five edges after input");
    a_ovf_cause: assert property (overflow_o |-> since_pix >= 4'h3)
        else $error("overflow without any pixel");
    c_stall: cover property (out_valid_o && !out_ready_i);
    c_line_end: cover property (out_valid_o && out_ready_i && out_last_o);
    c_frame: cover property (pix_valid_i && pix_sof_i);
    c_ovf: cover property ($rose(overflow_o));
endmodule
`default_nettype wire

// file: pbn_sensor_model.sv
// Purpose: Sensor readout model pacing pixels into the binning block.
// Assumes: Sensor cannot stall; one pixel per valid cycle.
// Notes: Data shows the inverse of the last pixel between pixels.
`timescale 1ns/1ps
`default_nettype none
module pbn_sensor_model (
    input wire logic clk_sys_i,
    output logic pix_valid_o,
    output logic [pbn_pkg::PIX_W-1:0] pix_data_o,
    output logic pix_sof_o,
    output logic pix_eol_o
);
    initial begin
        pix_valid_o = 1'b0;
        pix_data_o = 12'h000;
        pix_sof_o = 1'b0;
        pix_eol_o = 1'b0;
    end
    task automatic send(input logic [11:0] d, input logic sof, input logic eol);
        @(posedge clk_sys_i);
        pix_valid_o <= 1'b1;
        pix_data_o <= d;
        pix_sof_o <= sof;
        pix_eol_o <= eol;
        @(posedge clk_sys_i);
        pix_valid_o <= 1'b0;
        pix_data_o <= ~d;
        pix_sof_o <= 1'b0;
        pix_eol_o <= 1'b0;
        // Random gap covers prompt and slow readout
        repeat ($urandom % 2) @(posedge clk_sys_i);
    endtask
endmodule
`default_nettype wire

// file: tb_top.sv
// Purpose: Self-checking bench for the pixel binning datapath.
// Assumes: Sensor model paces pixels; sink stalls at random.
// Notes: Driver queues expected pixels, monitor pops them.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b1;
    logic scal = 1'b0;
    logic out_ready = 1'b1;
    logic hold = 1'b0;
    logic [2:0] mode = 3'h0;
    logic [11:0] black = 12'h000;
    logic [6:0] map_cfg = 7'h00;
    logic pix_valid, pix_sof, pix_eol, out_valid, out_last, src_ready, overflow;
    logic [11:0] pix_data, out_data;
    logic [12:0] exp_q[$];
    int errors = 0;
    int checked = 0;
    always #12.5 clk_sys_i = ~clk_sys_i;
    pbn_sensor_model u_pbn_sensor_model (.clk_sys_i(clk_sys_i), .pix_valid_o(pix_valid),
        .pix_data_o(pix_data), .pix_sof_o(pix_sof), .pix_eol_o(pix_eol));
    pbn_binning u_pbn_binning (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .pix_valid_i(pix_valid), .pix_data_i(pix_data), .pix_sof_i(pix_sof),
        .pix_eol_i(pix_eol), .fmt_scalable_i(scal), .mode_i(mode), .map_en_i(map_cfg[6]),
        .map_hfac_i(map_cfg[5:4]), .map_vfac_i(map_cfg[3:2]), .map_hsub_i(map_cfg[1]),
        .map_vsub_i(map_cfg[0]),
        .black_level_i(black), .out_valid_o(out_valid), .out_ready_i(out_ready),
        .out_data_o(out_data), .out_last_o(out_last), .src_ready_o(src_ready),
        .overflow_o(overflow));
    function automatic logic [11:0] sat(input logic [15:0] v);
        return (v > 16'h0FFF) ? pbn_pkg::PIX_MAX : v[11:0];
    endfunction
    task automatic chk(input string what, input logic [12:0] e, input logic [12:0] s);
        checked++;
        if (s !== e) begin
            errors++;
            $display("mismatch %s exp %h seen %h", what, e, s);
        end
    endtask
    task automatic summarize;
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clk_sys_i) out_ready <= hold ? 1'b0 : (($urandom % 4) != 0);
    always @(posedge clk_sys_i) begin
        if (rst_n_i && out_valid === 1'b1 && out_ready === 1'b1) begin
            if (exp_q.size() == 0) chk("extra", 13'h0000, 13'h1FFF);
            else chk("pixel", exp_q.pop_front(), {out_last, out_data});
        end
    end
    task automatic frame(input logic [2:0] m, input logic s, input logic [6:0] map);
        logic [11:0] vs [6];
        logic [11:0] d, b, v;
        logic [15:0] acc;
        logic hs, vsb, keep, flush;
        int hn, vn;
        hn = 1;
        vn = 1;
        hs = 1'b0;
        vsb = 1'b0;
        if (s && m != pbn_pkg::MODE_FULL_RES && map[6]) begin
            // Sub-sampling wins over binning in a remapped mode
            hs = map[1];
            vsb = map[0];
            if (!(hs || vsb)) begin
                hn = 1 << map[5:4];
                vn = 1 << map[3:2];
            end
        end else if (s) begin
            hn = (m == pbn_pkg::MODE_H_BIN2 || m == pbn_pkg::MODE_F_BIN2) ? 2 : 1;
            vn = (m == pbn_pkg::MODE_V_BIN2 || m == pbn_pkg::MODE_F_BIN2) ? 2 : 1;
            hs = (m == pbn_pkg::MODE_H_SUB || m == pbn_pkg::MODE_F_SUB);
            vsb = (m == pbn_pkg::MODE_V_SUB || m == pbn_pkg::MODE_F_SUB);
        end
        // Black level only where a horizontal sum removes it
        b = (hn > 1) ? 12'($urandom % 256) : 12'h000;
        // Black level is used live, so the last frame must clear compute first
        repeat (4) @(posedge clk_sys_i);
        mode <= m;
        scal <= s;
        black <= b;
        map_cfg <= map;
        for (int l = 0; l < 4; l++) begin
            acc = 16'h0000;
            keep = vsb ? (l % 4 < 2) : (l % vn == vn - 1);
            for (int c = 0; c < 6; c++) begin
                d = 12'($urandom);
                flush = (c % hn == hn - 1) || c == 5;
                if (l % vn == 0) vs[c] = 12'h000;
                vs[c] = sat(vs[c] + d);
                v = vs[c];
                acc = acc + 16'(v > b ? v - b : 12'h000);
                if (keep && !hs && hn == 1) exp_q.push_back({c == 5, v});
                if (keep && hs && c % 4 < 2) exp_q.push_back({c == 5, v});
                if (keep && hn > 1 && flush) exp_q.push_back({c == 5, sat(acc + 16'(b))});
                if (flush) acc = 16'h0000;
                u_pbn_sensor_model.send(d, l == 0 && c == 0, c == 5);
            end
        end
    endtask
    initial begin
        // Falls at time zero so every flop with a reset is cleared before the first edge
        rst_n_i <= 1'b0;
        void'($urandom(16));
        repeat (2) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        for (int m = 0; m < 8; m++) frame(3'(m), 1'b1, 7'h00);
        frame(pbn_pkg::MODE_H_BIN2, 1'b1, 7'h68);
        frame(pbn_pkg::MODE_H_BIN2, 1'b1, 7'h70);
        frame(pbn_pkg::MODE_H_BIN2, 1'b1, 7'h56);
        frame(pbn_pkg::MODE_FULL_RES, 1'b1, 7'h68);
        frame(pbn_pkg::MODE_F_BIN2, 1'b0, 7'h68);
        for (int i = 0; i < 400 && exp_q.size() > 0; i++) @(posedge clk_sys_i);
        chk("left", 13'(0), 13'(exp_q.size()));
        chk("overflow", 13'h0000, {12'h000, overflow});
        // Sink held off so the unstallable source must overrun
        hold = 1'b1;
        for (int i = 0; i < 12; i++) u_pbn_sensor_model.send(12'(i), i == 0, 1'b0);
        repeat (4) @(posedge clk_sys_i);
        chk("overflow", 13'h0001, {12'h000, overflow});
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        hold = 1'b0;
        repeat (2) @(posedge clk_sys_i);
        chk("restart", 13'h0001, {11'h000, overflow, src_ready});
        summarize();
    end
    initial begin
        #(25 * 20000);
        errors++;
        summarize();
    end
endmodule
bind pbn_binning pbn_binning_checker u_pbn_binning_checker (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .pix_valid_i(pix_valid_i), .pix_sof_i(pix_sof_i),
    .out_valid_o(out_valid_o), .out_ready_i(out_ready_i), .out_data_o(out_data_o),
    .out_last_o(out_last_o), .src_ready_o(src_ready_o), .overflow_o(overflow_o));
`default_nettype wire
